// *** design/pmcs_top.sv ***
/*
  Power-mode sequencer with slow oscillator, wake-up counter, card
  presence detect sequencing and command launch front end.
  Assumes hard_off_pin and all host inputs are synchronous to clk; argument
  counts per command come from the command decoder as arg_count.
*/
module pmcs_top (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Pins
  input  wire logic              hard_off_pin,
  input  wire logic              uart_rx_valid,
  input  wire logic [7:0]        uart_rx_byte,
  // Host command register and FIFO
  input  wire pmcs_pkg::pmcs_cmd_t cmd_in,
  input  wire logic [3:0]        arg_count,
  input  wire logic [7:0]        fifo_level,
  input  wire logic              cmd_done,
  // Detection configuration, trim request and reference tick, analog samples
  input  wire pmcs_pkg::pmcs_cfg_t cfg,
  input  wire logic              trim_req,
  input  wire logic              ref_tick,
  input  wire logic [7:0]        i_sample,
  input  wire logic [7:0]        q_sample,
  // Status and controls
  output logic                   core_on,
  output logic                   inputs_clamped,
  output logic                   pads_hiz,
  output logic                   rf_on,
  output logic                   ready,
  output logic                   cmd_start,
  output logic                   cmd_active,
  output logic [5:0]             cmd_code,
  output logic                   card_detect_irq,
  output logic [7:0]             i_sample_result,
  output logic [7:0]             q_sample_result,
  output logic [7:0]             slow_trim,
  output logic                   trim_done
);

  pmcs_pkg::pmcs_state_t s;
  pmcs_pkg::pmcs_state_t next_s;

  logic hit;
  logic wake_req;
  logic leave;
  logic i_out;
  logic q_out;

  // ***************************************************************
  // Derived counts
  // ***************************************************************
  localparam logic [pmcs_pkg::CW-1:0] SLOW_LAST =
    pmcs_pkg::CW'(pmcs_pkg::SLOW_DIV - 1);
  localparam logic [pmcs_pkg::CW-1:0] POR_LAST =
    pmcs_pkg::CW'(pmcs_pkg::POR_CYC - 1);
  localparam logic [pmcs_pkg::CW-1:0] STARTUP_LAST =
    pmcs_pkg::CW'(pmcs_pkg::STARTUP_CYC - 1);
  localparam logic [pmcs_pkg::CW-1:0] HARD_OFF_LIM =
    pmcs_pkg::CW'(pmcs_pkg::HARD_OFF_CYC);
  // Ideal slow period in reference ticks
  localparam logic [pmcs_pkg::CW-1:0] TRIM_IDEAL =
    pmcs_pkg::CW'(pmcs_pkg::REF_KHZ / pmcs_pkg::SLOW_KHZ);

  always_comb begin
    next_s = s;
    next_s.cmd_start = 1'b0;
    next_s.trim_done = 1'b0;
    hit = 1'b0;
    wake_req = 1'b0;
    leave = 1'b0;
    i_out = 1'b0;
    q_out = 1'b0;

    // ***************************************************************
    // Slow oscillator and wake-up counter
    // ***************************************************************
    next_s.slow_tick = 1'b0;
    if (s.core_on || s.pm == pmcs_pkg::PM_STANDBY) begin
      if (s.slow_div >= SLOW_LAST) begin
        next_s.slow_div = '0;
        next_s.slow_tick = 1'b1;
      end else begin
        next_s.slow_div = s.slow_div + pmcs_pkg::ONE;
      end
    end
    if (s.wt_run && s.slow_tick) begin
      if (s.wakeup_counter == '0) begin
        wake_req = cfg.wake_timer_auto_wake;
        next_s.wt_run = cfg.wake_timer_auto_reload;
        next_s.wakeup_counter = cfg.wake_timer_reload;
      end else begin
        next_s.wakeup_counter = s.wakeup_counter - pmcs_pkg::ONE;
      end
    end

    // ***************************************************************
    // Optional trimming against the crystal reference
    // ***************************************************************
    // A request waits for a slow edge so that a whole slow period is
    // measured; all ones in the reference count marks that wait
    if (trim_req && !s.trim_busy && s.pm == pmcs_pkg::PM_FULL) begin
      next_s.trim_busy = 1'b1;
      next_s.trim_ref = '1;
    end else if (s.trim_busy) begin
      if (s.slow_tick && s.trim_ref == '1) begin
        next_s.trim_ref = '0;
      end else if (s.slow_tick) begin
        // Slow period in reference ticks vs ideal 13560/16
        if (s.trim_ref > TRIM_IDEAL)
          next_s.trim = s.trim + 8'h01;
        else if (s.trim_ref < TRIM_IDEAL)
          next_s.trim = s.trim - 8'h01;
        next_s.trim_busy = 1'b0;
        next_s.trim_done = 1'b1;
      end else if (ref_tick && s.trim_ref != '1) begin
        next_s.trim_ref = s.trim_ref + pmcs_pkg::ONE;
      end
    end

    // ***************************************************************
    // Power modes
    // ***************************************************************
    unique case (s.pm)
      pmcs_pkg::PM_HARD_OFF: begin
        if (!hard_off_pin)
          next_s.pm_cnt = '0;
        // Saturating hold time; release alone starts the reset
        else if (s.pm_cnt < HARD_OFF_LIM)
          next_s.pm_cnt = s.pm_cnt + pmcs_pkg::ONE;
        if (!hard_off_pin) begin
          next_s.pm = pmcs_pkg::PM_POR;
        end
      end
      pmcs_pkg::PM_POR: begin
        next_s.pm_cnt = s.pm_cnt + pmcs_pkg::ONE;
        if (s.pm_cnt >= POR_LAST) begin
          next_s.pm = pmcs_pkg::PM_STARTUP;
          next_s.pm_cnt = '0;
        end
      end
      pmcs_pkg::PM_STARTUP: begin
        next_s.pm_cnt = s.pm_cnt + pmcs_pkg::ONE;
        if (s.pm_cnt >= STARTUP_LAST) begin
          next_s.pm = pmcs_pkg::PM_FULL;
          next_s.ready = 1'b1;
        end
      end
      pmcs_pkg::PM_FULL: begin
        if (cmd_in.wr && cmd_in.standby_request_bit) begin
          next_s.pm = pmcs_pkg::PM_STANDBY;
          next_s.stby_bit = 1'b1;
          next_s.ready = 1'b0;
        end
      end
      pmcs_pkg::PM_STANDBY: begin
        // Registers, FIFO and outputs simply hold
        if (cmd_in.wr && !cmd_in.standby_request_bit)
          leave = 1'b1;
        if (uart_rx_valid && uart_rx_byte == pmcs_pkg::UART_WAKE)
          leave = 1'b1;
        if (wake_req)
          leave = 1'b1;
        if (leave) begin
          next_s.pm = pmcs_pkg::PM_STARTUP;
          next_s.pm_cnt = '0;
          next_s.stby_bit = 1'b0;
        end
      end
      default: next_s.pm = pmcs_pkg::PM_HARD_OFF;
    endcase

    // Hard-off pin overrides every mode unless a detect end enters standby in the same cycle
    if (hard_off_pin && s.pm != pmcs_pkg::PM_HARD_OFF) begin
      next_s.pm = pmcs_pkg::PM_HARD_OFF;
      next_s.pm_cnt = '0;
      next_s.ready = 1'b0;
      next_s.stby_bit = 1'b0;
    end

    next_s.core_on = next_s.pm != pmcs_pkg::PM_HARD_OFF;
    next_s.inputs_clamped = !next_s.core_on;
    next_s.pads_hiz = !next_s.core_on;

    // ***************************************************************
    // Modem off
    // ***************************************************************
    if (cmd_in.wr && s.pm == pmcs_pkg::PM_FULL)
      next_s.modem_off = cmd_in.rf_frontend_off_bit;
    if (next_s.pm == pmcs_pkg::PM_HARD_OFF)
      next_s.modem_off = 1'b0;
    next_s.rf_on = next_s.pm == pmcs_pkg::PM_FULL
                   && !next_s.modem_off;

    // ***************************************************************
    // Command launch
    // ***************************************************************
    if (s.pm == pmcs_pkg::PM_FULL && cmd_in.wr
        && !cmd_in.standby_request_bit) begin
      next_s.cmd = cmd_in.code & pmcs_pkg::CMD_MASK;
      next_s.args_need = arg_count;
      next_s.cmd_active = 1'b0;
      if (cmd_in.code == pmcs_pkg::CMD_IDLE[5:0]) begin
        next_s.cs = pmcs_pkg::CS_IDLE;
      end else if (arg_count != 4'h0
                   && fifo_level < {4'h0, arg_count}) begin
        next_s.cs = pmcs_pkg::CS_WAIT_ARG;
      end else if (cmd_in.code == pmcs_pkg::CMD_DETECT[5:0]) begin
        next_s.cs = pmcs_pkg::CS_DETECT;
        next_s.win = cfg.detect_window_reload;
        next_s.cmd_active = 1'b1;
        next_s.cmd_start = 1'b1;
      end else begin
        next_s.cs = pmcs_pkg::CS_RUN;
        next_s.cmd_active = 1'b1;
        next_s.cmd_start = 1'b1;
      end
      if (cfg.wake_timer_start) begin
        next_s.wt_run = 1'b1;
        next_s.wakeup_counter = cfg.wake_timer_reload;
      end
    end else if (s.pm == pmcs_pkg::PM_FULL) begin
      unique case (s.cs)
        pmcs_pkg::CS_WAIT_ARG: begin
          if (fifo_level >= {4'h0, s.args_need}) begin
            next_s.cs = pmcs_pkg::CS_RUN;
            next_s.cmd_active = 1'b1;
            next_s.cmd_start = 1'b1;
          end
        end
        pmcs_pkg::CS_RUN: begin
          if (cmd_done) begin
            next_s.cs = pmcs_pkg::CS_IDLE;
            next_s.cmd_active = 1'b0;
          end
        end
        pmcs_pkg::CS_DETECT: begin
          if (s.win != '0) begin
            next_s.win = s.win - pmcs_pkg::ONE;
          end else begin
            next_s.i_sample_result = i_sample;
            next_s.q_sample_result = q_sample;
            i_out = i_sample < cfg.i_lower_limit
                    || i_sample > cfg.i_upper_limit;
            q_out = q_sample < cfg.q_lower_limit
                    || q_sample > cfg.q_upper_limit;
            hit = i_out || q_out;
            next_s.cmd_active = 1'b0;
            next_s.cs = pmcs_pkg::CS_IDLE;
            if (hit) begin
              next_s.card_detect_irq = 1'b1;
              next_s.wt_run = 1'b0;
            end else if (cfg.wake_timer_auto_wake && s.wt_run) begin
              next_s.pm = pmcs_pkg::PM_STANDBY;
              next_s.ready = 1'b0;
              next_s.cs = pmcs_pkg::CS_SLEEP;
            end
          end
        end
        default: next_s.cs = s.cs;
      endcase
    end

    // ***************************************************************
    // Detect re-arm, interrupt and hard-off cleanup
    // ***************************************************************
    // Re-arm detection after timer wake
    if (s.cs == pmcs_pkg::CS_SLEEP && s.pm == pmcs_pkg::PM_FULL) begin
      next_s.cs = pmcs_pkg::CS_DETECT;
      next_s.win = cfg.detect_window_reload;
      next_s.cmd_active = 1'b1;
    end
    // Irq clears when host writes a command; a new hit wins
    if (cmd_in.wr && s.pm == pmcs_pkg::PM_FULL && !hit)
      next_s.card_detect_irq = 1'b0;
    if (next_s.pm == pmcs_pkg::PM_HARD_OFF) begin
      next_s.cs = pmcs_pkg::CS_IDLE;
      next_s.cmd_active = 1'b0;
      next_s.wt_run = 1'b0;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Reset looks like hard-off so that outputs start high impedance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.pm <= pmcs_pkg::PM_HARD_OFF;
      s.cs <= pmcs_pkg::CS_IDLE;
      s.trim <= pmcs_pkg::TRIM_RESET;
      s.pads_hiz <= 1'b1;
      s.inputs_clamped <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign core_on         = s.core_on;
  assign inputs_clamped  = s.inputs_clamped;
  assign pads_hiz        = s.pads_hiz;
  assign rf_on           = s.rf_on;
  assign ready           = s.ready;
  assign cmd_start       = s.cmd_start;
  assign cmd_active      = s.cmd_active;
  assign cmd_code        = s.cmd;
  assign card_detect_irq = s.card_detect_irq;
  assign i_sample_result = s.i_sample_result;
  assign q_sample_result = s.q_sample_result;
  assign slow_trim       = s.trim;
  assign trim_done       = s.trim_done;

endmodule // pmcs_top

// *** design/pmcs_pkg.sv ***
/*
  Constants and carrier types for the power-mode sequencer and command
  launcher. Assumes a 250 MHz system clock and a host that presents decoded
  command register writes and FIFO fill level as plain ports.
*/
package pmcs_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_MHZ          = 250;
  localparam int SLOW_KHZ         = 16;
  localparam int SLOW_DIV         = (CLK_MHZ * 1000) / SLOW_KHZ;
  localparam int REF_KHZ          = 13560;
  localparam int REF_DIV          = (CLK_MHZ * 1000) / REF_KHZ;
  localparam int HARD_OFF_NS      = 10000;
  localparam int HARD_OFF_CYC     = (HARD_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_NS       = 15000;
  localparam int STARTUP_CYC      = (STARTUP_NS * CLK_MHZ) / 1000;
  localparam int POR_CYC          = 16;
  localparam int CW               = 16;

  // ***************************************************************
  // Codes
  // ***************************************************************
  localparam logic [7:0] CMD_IDLE     = 8'h00;
  localparam logic [7:0] CMD_DETECT   = 8'h01;
  localparam logic [7:0] UART_WAKE    = 8'h55;
  localparam logic [5:0] CMD_MASK     = 6'h3f;
  localparam logic [7:0] TRIM_RESET   = 8'h80;
  localparam logic [CW-1:0] ONE       = 16'h0001;

  typedef enum logic [2:0] {
    PM_HARD_OFF = 3'b000,
    PM_POR      = 3'b001,
    PM_STARTUP  = 3'b011,
    PM_FULL     = 3'b010,
    PM_STANDBY  = 3'b110
  } pmcs_pm_t;

  typedef enum logic [2:0] {
    CS_IDLE     = 3'b000,
    CS_WAIT_ARG = 3'b001,
    CS_RUN      = 3'b011,
    CS_DETECT   = 3'b010,
    CS_SLEEP    = 3'b110
  } pmcs_cs_t;

  // Host command register write
  typedef struct packed {
    logic       wr;
    logic [5:0] code;
    logic       standby_request_bit;
    logic       rf_frontend_off_bit;
  } pmcs_cmd_t;

  // Card presence detect configuration
  typedef struct packed {
    logic [7:0] i_lower_limit;
    logic [7:0] i_upper_limit;
    logic [7:0] q_lower_limit;
    logic [7:0] q_upper_limit;
    logic       wake_timer_auto_wake;
    logic       wake_timer_auto_reload;
    logic       wake_timer_start;
    logic [CW-1:0] wake_timer_reload;
    logic [CW-1:0] detect_window_reload;
  } pmcs_cfg_t;

  typedef struct packed {
    pmcs_pm_t      pm;
    pmcs_cs_t      cs;
    logic [CW-1:0] pm_cnt;
    logic          stby_bit;
    logic          modem_off;
    logic [5:0]    cmd;
    logic [3:0]    args_need;
    logic [CW-1:0] slow_div;
    logic          slow_tick;
    logic [CW-1:0] wakeup_counter;
    logic          wt_run;
    logic [CW-1:0] win;
    logic [7:0]    i_sample_result;
    logic [7:0]    q_sample_result;
    logic          card_detect_irq;
    logic          ready;
    logic          core_on;
    logic          pads_hiz;
    logic          inputs_clamped;
    logic          rf_on;
    logic          cmd_start;
    logic          cmd_active;
    logic [7:0]    trim;
    logic          trim_busy;
    logic [CW-1:0] trim_ref;
    logic          trim_done;
  } pmcs_state_t;

endpackage

// *** dv/pmcs_asserts.sv ***
/*
  Port checker for pmcs_top.
  Assumes a bind from the bench top file.
*/
module pmcs_asserts (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Inputs
  input wire logic                hard_off_pin,
  input wire pmcs_pkg::pmcs_cmd_t cmd_in,
  input wire logic [3:0]          arg_count,
  input wire logic [7:0]          fifo_level,
  input wire pmcs_pkg::pmcs_cfg_t cfg,
  // Outputs
  input wire logic                core_on,
  input wire logic                pads_hiz,
  input wire logic                rf_on,
  input wire logic                ready,
  input wire logic                cmd_start,
  input wire logic                cmd_active,
  input wire logic                card_detect_irq,
  input wire logic [7:0]          i_sample_result,
  input wire logic [7:0]          q_sample_result
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        go;
  logic        enough;
  logic        boot_arm;
  logic [15:0] boot_cnt;
  assign go = ready && cmd_in.wr && !cmd_in.standby_request_bit
              && !hard_off_pin;
  assign enough = {4'h0, arg_count} <= fifo_level;

  // Cycles since the hard-off pin fell, until ready first shows
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_arm <= 1'b0;
      boot_cnt <= 16'h0000;
    end else if ($fell(hard_off_pin)) begin
      boot_arm <= 1'b1;
      boot_cnt <= 16'h0001;
    end else if (ready) begin
      boot_arm <= 1'b0;
    end else if (boot_arm) begin
      boot_cnt <= boot_cnt + 16'h0001;
    end
  end

  AST_HARD_OFF: assert property (
    hard_off_pin |=> !core_on && pads_hiz)
    else $error("hard-off pin did not power down");
  AST_STBY: assert property (
    ready && cmd_in.wr && cmd_in.standby_request_bit |=> !ready)
    else $error("standby not entered at once");
  AST_START: assert property (
    go && cmd_in.code != 6'h00 && enough |=> cmd_start)
    else $error("command did not start");
  AST_ARGS: assert property (
    go && !enough |=> !cmd_start)
    else $error("command started without its arguments");
  AST_IDLE: assert property (
    go && cmd_in.code == 6'h00 |=> !cmd_active && !cmd_start)
    else $error("idle code did not cancel");
  AST_ASLEEP: assert property (
    !ready && !$past(ready) |-> !cmd_start)
    else $error("command started while not ready");
  AST_RF: assert property (
    go |=> rf_on == !$past(cmd_in.rf_frontend_off_bit))
    else $error("front end state wrong after write");
  AST_BOOT: assert property (
    boot_arm |-> boot_cnt <= 16'h0ebc && (!ready || boot_cnt >= 16'h0eb0))
    else $error("start-up length wrong");
  AST_IRQ: assert property (
    $rose(card_detect_irq) |-> i_sample_result < cfg.i_lower_limit
    || i_sample_result > cfg.i_upper_limit
    || q_sample_result < cfg.q_lower_limit
    || q_sample_result > cfg.q_upper_limit)
    else $error("detect irq inside limits");
endmodule // pmcs_asserts

// *** dv/pmcs_host_model.sv ***
/*
  Host side model: sends the UART wake byte and polls for readiness.
  Assumes the bench pulses wake_go while the device is in standby.
*/
module pmcs_host_model (
  // Clock, trigger and ready
  input wire logic   clk,
  input wire logic   wake_go,
  input wire logic   ready,
  // UART line and status
  output logic       uart_rx_valid,
  output logic [7:0] uart_rx_byte,
  output logic       awake
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    uart_rx_valid = 1'b0;
    uart_rx_byte = 8'haa;
    awake = 1'b0;
    forever begin
      @(posedge wake_go);
      @(negedge clk);
      awake = 1'b0;
      uart_rx_byte = 8'h55;
      uart_rx_valid = 1'b1;
      @(negedge clk);
      uart_rx_valid = 1'b0;
      uart_rx_byte = 8'haa;
      for (int i = 0; i < 5000 && !ready; i++) @(negedge clk);
      awake = ready;
    end
  end
endmodule // pmcs_host_model

// *** dv/pmcs_top_tb.sv ***
/*
  Self-checking bench for pmcs_top.
  Assumes the checker and host model are compiled first.
*/
module pmcs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals
  // ****************
  logic clk = 1'b0;
  logic rst_n, hard_off_pin, cmd_done, wake_go, awake, uart_rx_valid;
  logic core_on, inputs_clamped, pads_hiz, rf_on, ready, cmd_start;
  logic cmd_active, card_detect_irq, trim_done;
  logic trim_req;
  logic ref_tick = 1'b0;
  logic [7:0] uart_rx_byte, fifo_level, i_sample, q_sample, slow_trim;
  logic [7:0] i_sample_result, q_sample_result;
  logic [5:0] cmd_code;
  logic [3:0] arg_count;
  pmcs_pkg::pmcs_cmd_t cmd;
  pmcs_pkg::pmcs_cfg_t cfg;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ref_cnt = 0;

  always #2 clk = ~clk;

  // Reference enable at the crystal rate
  always @(negedge clk) begin
    ref_cnt = (ref_cnt + 1) % pmcs_pkg::REF_DIV;
    ref_tick = ref_cnt == 0;
  end

  pmcs_top u_dut (.clk, .rst_n, .hard_off_pin, .uart_rx_valid,
    .uart_rx_byte, .cmd_in(cmd), .arg_count, .fifo_level, .cmd_done,
    .cfg, .trim_req, .ref_tick, .i_sample, .q_sample,
    .core_on, .inputs_clamped, .pads_hiz, .rf_on, .ready, .cmd_start,
    .cmd_active, .cmd_code, .card_detect_irq, .i_sample_result,
    .q_sample_result, .slow_trim, .trim_done);
  pmcs_host_model u_host (.clk, .wake_go, .ready, .uart_rx_valid,
    .uart_rx_byte, .awake);

  // ****************
  // Tasks
  // ****************
  task automatic check(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [5:0] code, logic sb, logic rf, logic [3:0] n);
    @(negedge clk);
    cmd = '{1'b1, code, sb, rf};
    arg_count = n;
    @(negedge clk);
    cmd.wr = 1'b0;
  endtask
  task automatic boot(int lo, int hi);
    int n;
    n = 0;
    while (!ready && n < hi + 10) begin
      @(negedge clk);
      n++;
    end
    check(8'(n >= lo && n <= hi), 8'h01);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      summarize();
    end
  end

  // ****************
  // Tests
  // ****************
  initial begin
    rst_n = 1'b0;
    hard_off_pin = 1'b0;
    cmd = '0;
    arg_count = 4'h0;
    fifo_level = 8'h00;
    cmd_done = 1'b0;
    trim_req = 1'b0;
    wake_go = 1'b0;
    i_sample = 8'h18;
    q_sample = 8'h18;
    cfg = '{8'h10, 8'h20, 8'h10, 8'h20, 1'b0, 1'b0, 1'b0, 16'h1, 16'h4};
    repeat (5) @(negedge clk);
    check(core_on, 1'b0);
    check(pads_hiz, 1'b1);
    check(slow_trim, 8'h80);
    rst_n = 1'b1;
    boot(3760, 3772);
    $display("test reset done");
    wr(6'h06, 1'b0, 1'b0, 4'h0);
    check(cmd_start, 1'b1);
    check(cmd_code, 6'h06);
    cmd_done = 1'b1;
    @(negedge clk);
    cmd_done = 1'b0;
    @(negedge clk);
    check(cmd_active, 1'b0);
    fifo_level = 8'h02;
    wr(6'h02, 1'b0, 1'b0, 4'h6);
    repeat (4) begin
      check(cmd_start, 1'b0);
      @(negedge clk);
    end
    fifo_level = 8'h06;
    repeat (4) if (!cmd_start) @(negedge clk);
    check(cmd_start, 1'b1);
    wr(6'h00, 1'b0, 1'b0, 4'h0);
    check(cmd_active, 1'b0);
    wr(6'h02, 1'b0, 1'b0, 4'h6);
    check(cmd_start, 1'b1);
    wr(6'h06, 1'b0, 1'b0, 4'h0);
    check(cmd_code, 6'h06);
    wr(6'h00, 1'b0, 1'b1, 4'h0);
    check(rf_on, 1'b0);
    wr(6'h00, 1'b0, 1'b0, 4'h0);
    check(rf_on, 1'b1);
    $display("test command done");
    wr(6'h07, 1'b0, 1'b0, 4'h0);
    wr(6'h07, 1'b1, 1'b0, 4'h0);
    check(ready, 1'b0);
    repeat (50) @(negedge clk);
    wr(6'h03, 1'b1, 1'b0, 4'h0);
    check(cmd_start, 1'b0);
    check(cmd_code, 6'h07);
    wr(6'h07, 1'b0, 1'b0, 4'h0);
    boot(3740, 3760);
    check(cmd_code, 6'h07);
    wr(6'h07, 1'b1, 1'b0, 4'h0);
    wake_go = 1'b1;
    @(negedge clk);
    wake_go = 1'b0;
    repeat (5000) if (!awake) @(negedge clk);
    check(awake, 1'b1);
    $display("test standby done");
    i_sample = 8'h30;
    wr(6'h01, 1'b0, 1'b0, 4'h0);
    repeat (40) if (!card_detect_irq) @(negedge clk);
    check(card_detect_irq, 1'b1);
    check(i_sample_result, 8'h30);
    check(q_sample_result, 8'h18);
    i_sample = 8'h18;
    wr(6'h01, 1'b0, 1'b0, 4'h0);
    repeat (40) @(negedge clk);
    check(card_detect_irq, 1'b0);
    check(i_sample_result, 8'h18);
    check(ready, 1'b1);
    cfg.wake_timer_auto_wake = 1'b1;
    cfg.wake_timer_auto_reload = 1'b1;
    cfg.wake_timer_start = 1'b1;
    wr(6'h01, 1'b0, 1'b0, 4'h0);
    repeat (40) if (ready) @(negedge clk);
    check(ready, 1'b0);
    cfg.wake_timer_auto_reload = 1'b0;
    boot(3740, 36000);
    cfg.wake_timer_auto_wake = 1'b0;
    cfg.wake_timer_start = 1'b0;
    $display("test detect done");
    trim_req = 1'b1;
    @(negedge clk);
    trim_req = 1'b0;
    repeat (32000) if (!trim_done) @(negedge clk);
    check(trim_done, 1'b1);
    check(slow_trim, 8'h81);
    $display("test trim done");
    hard_off_pin = 1'b1;
    repeat (2600) @(negedge clk);
    check(core_on, 1'b0);
    check(inputs_clamped, 1'b1);
    check(pads_hiz, 1'b1);
    hard_off_pin = 1'b0;
    boot(3760, 3772);
    $display("test hard off done");
    summarize();
  end
endmodule // pmcs_top_tb

bind pmcs_top pmcs_asserts u_chk (.clk, .rst_n, .hard_off_pin, .cmd_in,
  .arg_count, .fifo_level, .cfg, .core_on, .pads_hiz, .rf_on, .ready,
  .cmd_start, .cmd_active, .card_detect_irq, .i_sample_result,
  .q_sample_result);
